// *** core/scs_defines.svh ***
// Constants for the smart card session sequencer: times, counts and word fields
`ifndef SCS_DEFINES_SVH
`define SCS_DEFINES_SVH
// System clock period in ns (100 MHz)
`define SCS_CLK_NS 10
// Sequencer time unit T in ns, and in system cycles
`define SCS_T_NS 25000
`define SCS_T_CYC (`SCS_T_NS / `SCS_CLK_NS)
// Oscillator periods per T, and system cycles per oscillator period
`define SCS_OSC_PER_T 64
`define SCS_OSC_CYC (`SCS_T_CYC / `SCS_OSC_PER_T)
// Power-on hold time and its cycle count
`define SCS_HOLD_US 220
`define SCS_HOLD_CYC (`SCS_HOLD_US * 1000 / `SCS_CLK_NS)
// Card insertion debounce time and its cycle count
`define SCS_DEB_MS 8
`define SCS_DEB_CYC (`SCS_DEB_MS * 1000000 / `SCS_CLK_NS)
// Data line edge delay and active pull-up interval, least times, rounded up
`define SCS_EDGE_NS 50
`define SCS_EDGE_CYC ((`SCS_EDGE_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
`define SCS_PU_NS 100
`define SCS_PU_CYC ((`SCS_PU_NS + `SCS_CLK_NS - 1) / `SCS_CLK_NS)
// Activation steps, in oscillator periods after t0 (t1 taken equal to t0)
`define SCS_TK_VCC_UP 96
`define SCS_TK_IO_ON 256
`define SCS_TK_CLK_ON 257
`define SCS_TK_RST_ON 448
// Deactivation steps, in oscillator periods after t10
`define SCS_TK_CLK_OFF 32
`define SCS_TK_IO_OFF 64
`define SCS_TK_VCC_OFF 96
// Contact word fields and FIFO shape
`define SCS_W_VCC 0
`define SCS_W_IO 1
`define SCS_W_CLK 2
`define SCS_W_RST 3
`define SCS_WORD_W 4
`define SCS_FIFO_D 4
// Reset values of the contact word and of the status output
`define SCS_WORD_RST 4'h0
`define SCS_ALERT_RST 1'b0
`endif

// *** core/scs_pkg.sv ***
// Types shared by the smart card session sequencer
package scs_pkg;
	// Sequencer states
	typedef enum logic [5:0] {
		SCS_HOLD = 6'b00_0001,
		SCS_IDLE = 6'b00_0010,
		SCS_ACT = 6'b00_0100,
		SCS_ON = 6'b00_1000,
		SCS_DEACT = 6'b01_0000,
		SCS_WAITV = 6'b10_0000
	} scs_seq_e;
	// Data line arbiter states
	typedef enum logic [4:0] {
		SCS_L_IDLE = 5'b0_0001,
		SCS_L_HOST = 5'b0_0010,
		SCS_L_CARD = 5'b0_0100,
		SCS_L_PU_C = 5'b0_1000,
		SCS_L_PU_H = 5'b1_0000
	} scs_line_e;
	// Card supply level select
	typedef enum logic [1:0] {
		SCS_V3 = 2'h0,
		SCS_V5 = 2'h1,
		SCS_V18 = 2'h2
	} scs_vsel_e;
	// Input pins gathered for synchronisation
	typedef struct packed {
		logic sess_n;
		logic rst_req;
		logic sel_a;
		logic sel_b;
		logic card_present_in;
		logic sup_ok;
		logic vcc_zero;
		logic f_ovl;
		logic f_gen;
		logic f_heat;
		logic lv;
		logic hm;
		logic xtal;
		logic [2:0] host;
		logic [2:0] card;
	} scs_pins_s;
endpackage : scs_pkg

// *** core/scs_stream_if.sv ***
// Valid/ready carrier for contact words between the sequencer and its FIFO
`include "scs_defines.svh"
interface scs_stream_if;
	logic valid;
	logic ready;
	logic [`SCS_WORD_W-1:0] data;
	modport src (output valid, output data, input ready);
	modport snk (input valid, input data, output ready);
endinterface : scs_stream_if

// *** core/scs_fifo.sv ***
// Small synchronous FIFO with valid/ready on both sides
module scs_fifo #(
	parameter int W = 4,
	parameter int D = 4
) (
	input wire logic i_clk,
	input wire logic i_rst,
	scs_stream_if.snk s_in,
	scs_stream_if.src s_out
);
	import scs_pkg::*;
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	logic [W-1:0] mem_q [D];
	logic [W-1:0] mem_d [D];
	logic [AW-1:0] wr_q, wr_d, rd_q, rd_d;
	logic [AW:0] cnt_q, cnt_d;
	logic push, pop;

	// Full and empty come straight from the fill count
	assign s_in.ready = (cnt_q != (AW+1)'(D));
	assign s_out.valid = (cnt_q != '0);
	assign s_out.data = mem_q[rd_q];
	assign push = s_in.valid & s_in.ready;
	assign pop = s_out.valid & s_out.ready;

	// Next pointers, count and storage
	always_comb
	begin
		mem_d = mem_q;
		wr_d = wr_q;
		rd_d = rd_q;
		cnt_d = cnt_q;
		if (push)
		begin
			mem_d[wr_q] = s_in.data;
			wr_d = (wr_q == AW'(D - 1)) ? '0 : wr_q + 1'b1;
		end
		if (pop)
			rd_d = (rd_q == AW'(D - 1)) ? '0 : rd_q + 1'b1;
		if (push && !pop)
			cnt_d = cnt_q + 1'b1;
		else if (pop && !push)
			cnt_d = cnt_q - 1'b1;
	end

	// Register only
	always_ff @(posedge i_clk)
	begin
		mem_q <= mem_d;
		if (i_rst)
		begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
		end
		else
		begin
			wr_q <= wr_d;
			rd_q <= rd_d;
			cnt_q <= cnt_d;
		end
	end
endmodule : scs_fifo

// *** core/scs_seq.sv ***
// Smart card session sequencer: activation, deactivation, card clock, data lines
//
// Function
// - Power-on hold keeps interface inactive
// - Commands ignored in hold; supply drop deactivates
// - Card clock is crystal divided by select
// - Each card clock state lasts whole divider spans
// - Ratio switches only at state boundaries
// - Clock starts at t4, else follows crystal
// - First falling side masters, slave drives low
// - Slave pulls high briefly, then idle
// - Inactive: contacts low, host lines undriven
// - Outside session and hold, status shows card presence
// - Activation steps timed from session request fall
// - Reset request fall starts clock early
// - Card reset low until t5, then follows
// - Without request, clock starts after t3
// - Deactivation steps timed from session rise
// - Supply down: contacts low, oscillator slow
// - Session fault drops status, deactivates
// - Outside session only supply drop matters
// - Insertion debounced, extraction acts at once
// - Low voltage select overrides mid select
// - Status output is active-low alert
`include "scs_defines.svh"
module scs_seq #(
	parameter int unsigned HOLD_CYC = `SCS_HOLD_CYC,
	parameter int unsigned DEB_CYC = `SCS_DEB_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_session_request_n,
	input wire logic i_card_present_in,
	input wire logic i_host_card_reset_req,
	input wire logic i_divide_select_a,
	input wire logic i_divide_select_b,
	input wire logic i_crystal_clock_in,
	input wire logic i_low_voltage_select,
	input wire logic i_high_mid_voltage_select,
	input wire logic i_supply_ok,
	input wire logic i_vcc_inactive,
	input wire logic i_fault_overload,
	input wire logic i_fault_gen_range,
	input wire logic i_fault_overheat,
	input wire logic [2:0] i_host_line_in,
	input wire logic [2:0] i_card_line_in,
	output logic o_card_clk,
	output logic o_card_rst,
	output logic o_vcc_en,
	output scs_pkg::scs_vsel_e o_vcc_sel,
	output logic o_gen_en,
	output logic o_osc_high,
	output logic o_hold,
	output logic o_alert_n,
	output logic [2:0] o_card_line_out,
	output logic [2:0] o_card_line_oe_n,
	output logic [2:0] o_host_line_out,
	output logic [2:0] o_host_line_oe_n
);
	import scs_pkg::*;

	// Half-period of the card clock in crystal edges for a select code
	function automatic logic [3:0] half_edges(input logic a, input logic b);
		case ({a, b})
			2'b00: half_edges = 4'h8;
			2'b01: half_edges = 4'h4;
			2'b11: half_edges = 4'h2;
			default: half_edges = 4'h1;
		endcase
	endfunction : half_edges

	// ****************************************
	// Input synchronisers
	// ****************************************
	scs_pins_s raw, s1_q, s2_q;
	logic xtal3_q; // Edge detector stage, fed from the second flop only
	logic [2:0] hp_q, cp_q; // Previous synced line levels
	logic sess_prev_q; // Previous synced session request

	assign raw = '{sess_n: i_session_request_n, rst_req: i_host_card_reset_req,
		sel_a: i_divide_select_a, sel_b: i_divide_select_b, card_present_in: i_card_present_in,
		sup_ok: i_supply_ok, vcc_zero: i_vcc_inactive, f_ovl: i_fault_overload,
		f_gen: i_fault_gen_range, f_heat: i_fault_overheat, lv: i_low_voltage_select,
		hm: i_high_mid_voltage_select, xtal: i_crystal_clock_in,
		host: i_host_line_in, card: i_card_line_in};

	// Two flops on every pin, reset low; previous line levels reset high to match their pull-ups
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s1_q <= '0;
			s2_q <= '0;
			xtal3_q <= 1'b0;
			hp_q <= 3'h7;
			cp_q <= 3'h7;
			sess_prev_q <= 1'b1;
		end
		else
		begin
			s1_q <= raw;
			s2_q <= s1_q;
			xtal3_q <= s2_q.xtal;
			hp_q <= s2_q.host;
			cp_q <= s2_q.card;
			sess_prev_q <= s2_q.sess_n;
		end
	end

	// ****************************************
	// Oscillator tick, presence debounce, power-on hold
	// ****************************************
	logic [5:0] osc_q, osc_d;
	logic tick;
	logic [19:0] deb_q, deb_d;
	logic card_present_in_q, card_present_in_d;
	logic [19:0] hold_q, hold_d;
	scs_seq_e st_q, st_d; // Sequencer state, declared here for the period restart

	assign tick = (osc_q == 6'(`SCS_OSC_CYC - 1));

	// Next values of the timing counters
	always_comb
	begin
		osc_d = tick ? 6'h0 : osc_q + 6'h1;
		// Restart the period count at each trigger so every step lands whole oscillator periods after it
		if (st_d != st_q && (st_d == SCS_ACT || st_d == SCS_DEACT))
			osc_d = 6'h0;
		deb_d = deb_q;
		card_present_in_d = card_present_in_q;
		// Extraction clears presence on the first low sample
		if (!s2_q.card_present_in)
		begin
			deb_d = '0;
			card_present_in_d = 1'b0;
		end
		else if (!card_present_in_q)
		begin
			if (deb_q == 20'(DEB_CYC - 1))
				card_present_in_d = 1'b1;
			else
				deb_d = deb_q + 20'h1;
		end
		// Hold count restarts whenever the supply is low
		if (!s2_q.sup_ok)
			hold_d = '0;
		else if (hold_q != 20'(HOLD_CYC))
			hold_d = hold_q + 20'h1;
		else
			hold_d = hold_q;
	end

	// Register only
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			osc_q <= '0;
			deb_q <= '0;
			card_present_in_q <= 1'b0;
			hold_q <= '0;
		end
		else
		begin
			osc_q <= osc_d;
			deb_q <= deb_d;
			card_present_in_q <= card_present_in_d;
			hold_q <= hold_d;
		end
	end

	// ****************************************
	// Session sequencer
	// ****************************************
	logic [9:0] tk_q, tk_d; // Oscillator periods since the last trigger
	logic [`SCS_WORD_W-1:0] want_q, want_d; // Contact state wanted now
	logic [`SCS_WORD_W-1:0] sent_q, sent_d; // Last contact state queued
	logic alt_q, alt_d; // Host asked for request-timed clock start
	logic fault_q, fault_d;
	logic alert_q, alert_d;
	logic in_sess, fault_now;
	scs_stream_if q_in ();
	scs_stream_if q_out ();

	assign in_sess = (st_q == SCS_ACT) || (st_q == SCS_ON);
	// Faults, supply loss and extraction only count during activation and the session
	assign fault_now = in_sess && (s2_q.f_ovl || s2_q.f_gen || s2_q.f_heat
		|| !s2_q.sup_ok || !card_present_in_q);
	// Any change of the wanted state is queued toward the contacts
	assign q_in.valid = (want_q != sent_q);
	assign q_in.data = want_q;

	// Next sequencer state
	always_comb
	begin
		st_d = st_q;
		tk_d = (tick && tk_q != 10'h3ff) ? tk_q + 10'h1 : tk_q;
		want_d = want_q;
		sent_d = (q_in.valid && q_in.ready) ? want_q : sent_q;
		alt_d = alt_q;
		fault_d = fault_q | fault_now; // The idle clear comes later and wins over this
		case (st_q)
			SCS_HOLD:
			begin
				// Commands are ignored until the hold has run out
				if (hold_q == 20'(HOLD_CYC))
					st_d = SCS_IDLE;
			end
			SCS_IDLE:
			begin
				if (s2_q.sess_n)
					fault_d = 1'b0;
				if (!s2_q.sup_ok)
					st_d = SCS_HOLD;
				else if (sess_prev_q && !s2_q.sess_n && card_present_in_q)
				begin
					st_d = SCS_ACT;
					tk_d = '0;
					alt_d = s2_q.rst_req;
				end
			end
			SCS_ACT:
			begin
				if (tk_q >= 10'(`SCS_TK_VCC_UP))
					want_d[`SCS_W_VCC] = 1'b1;
				if (tk_q >= 10'(`SCS_TK_IO_ON))
					want_d[`SCS_W_IO] = 1'b1;
				// One oscillator period after t3 exceeds the 200 ns gap
				if (tk_q >= 10'(`SCS_TK_CLK_ON) && (!alt_q || !s2_q.rst_req))
					want_d[`SCS_W_CLK] = 1'b1;
				if (tk_q >= 10'(`SCS_TK_RST_ON))
				begin
					want_d[`SCS_W_CLK] = 1'b1;
					want_d[`SCS_W_RST] = 1'b1;
					st_d = SCS_ON;
				end
				if (s2_q.sess_n || fault_now)
				begin
					st_d = SCS_DEACT;
					tk_d = '0;
				end
			end
			SCS_ON:
			begin
				if (s2_q.sess_n || fault_now)
				begin
					st_d = SCS_DEACT;
					tk_d = '0;
				end
			end
			SCS_DEACT:
			begin
				want_d[`SCS_W_RST] = 1'b0;
				if (tk_q >= 10'(`SCS_TK_CLK_OFF))
					want_d[`SCS_W_CLK] = 1'b0;
				if (tk_q >= 10'(`SCS_TK_IO_OFF))
					want_d[`SCS_W_IO] = 1'b0;
				if (tk_q >= 10'(`SCS_TK_VCC_OFF))
				begin
					want_d[`SCS_W_VCC] = 1'b0;
					st_d = SCS_WAITV;
				end
			end
			SCS_WAITV:
			begin
				// Done once the supply is down and the queue has drained
				if (s2_q.vcc_zero && !q_in.valid && !q_out.valid)
					st_d = s2_q.sup_ok ? SCS_IDLE : SCS_HOLD;
			end
			default:
			begin
				st_d = SCS_HOLD;
				want_d = `SCS_WORD_RST;
			end
		endcase
		// Status keeps its level through a hold
		alert_d = (st_q == SCS_HOLD) ? alert_q : (card_present_in_d & ~fault_d);
	end

	// Register only
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			st_q <= SCS_HOLD;
			tk_q <= '0;
			want_q <= `SCS_WORD_RST;
			sent_q <= `SCS_WORD_RST;
			alt_q <= 1'b0;
			fault_q <= 1'b0;
			alert_q <= `SCS_ALERT_RST;
		end
		else
		begin
			st_q <= st_d;
			tk_q <= tk_d;
			want_q <= want_d;
			sent_q <= sent_d;
			alt_q <= alt_d;
			fault_q <= fault_d;
			alert_q <= alert_d;
		end
	end

	// Queue between the sequencer and the contact stage
	scs_fifo #(
		.W(`SCS_WORD_W),
		.D(`SCS_FIFO_D)
	) u_fifo (
		.i_clk(i_clk),
		.i_rst(i_rst),
		.s_in(q_in.snk),
		.s_out(q_out.src)
	);

	// ****************************************
	// Contact stage: card clock divider and applied word
	// ****************************************
	logic [`SCS_WORD_W-1:0] app_q, app_d; // Contact state in force
	logic [2:0] hc_q, hc_d; // Crystal edges in this half period
	logic [3:0] div_q, div_d; // Ratio latched at a state boundary
	logic ph_q, ph_d; // Free-running divided phase
	logic clk_d;
	logic xedge;

	assign xedge = s2_q.xtal ^ xtal3_q;
	// Words that gate the clock land only while it is low, so no pulse is cut;
	// all other words land at once and keep their step timing
	assign q_out.ready = ~ph_q | (q_out.data[`SCS_W_CLK] == app_q[`SCS_W_CLK]);

	// Next divider and contact values
	always_comb
	begin
		hc_d = hc_q;
		div_d = div_q;
		ph_d = ph_q;
		app_d = (q_out.valid && q_out.ready) ? q_out.data : app_q;
		if (xedge)
		begin
			if ({1'b0, hc_q} == div_q - 4'h1)
			begin
				ph_d = ~ph_q;
				hc_d = '0;
				div_d = half_edges(s2_q.sel_a, s2_q.sel_b);
			end
			else
				hc_d = hc_q + 3'h1;
		end
		clk_d = ph_d & app_d[`SCS_W_CLK];
	end

	// Register only
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			hc_q <= '0;
			div_q <= 4'h8;
			ph_q <= 1'b0;
			app_q <= `SCS_WORD_RST;
		end
		else
		begin
			hc_q <= hc_d;
			div_q <= div_d;
			ph_q <= ph_d;
			app_q <= app_d;
		end
	end

	// ****************************************
	// Data line arbiters and output flops
	// ****************************************
	scs_line_e ln_q [3];
	scs_line_e ln_d [3];
	logic [3:0] dl_q [3];
	logic [3:0] dl_d [3];
	logic [2:0] co_d, coe_d, ho_d, hoe_d;
	logic io_on;

	assign io_on = app_q[`SCS_W_IO];

	// Next state of each line pair; drive values follow the state
	always_comb
	begin
		for (int i = 0; i < 3; i++)
		begin
			ln_d[i] = ln_q[i];
			dl_d[i] = (dl_q[i] != 4'hf) ? dl_q[i] + 4'h1 : dl_q[i];
			co_d[i] = 1'b0;
			coe_d[i] = 1'b1;
			ho_d[i] = 1'b0;
			hoe_d[i] = 1'b1;
			case (ln_q[i])
				SCS_L_IDLE:
				begin
					dl_d[i] = '0;
					if (hp_q[i] && !s2_q.host[i])
						ln_d[i] = SCS_L_HOST;
					else if (cp_q[i] && !s2_q.card[i])
						ln_d[i] = SCS_L_CARD;
				end
				SCS_L_HOST:
				begin
					// Card side edges are ignored while the host leads
					coe_d[i] = (dl_q[i] < 4'(`SCS_EDGE_CYC));
					if (s2_q.host[i])
					begin
						ln_d[i] = SCS_L_PU_C;
						dl_d[i] = '0;
					end
				end
				SCS_L_CARD:
				begin
					hoe_d[i] = (dl_q[i] < 4'(`SCS_EDGE_CYC));
					if (s2_q.card[i])
					begin
						ln_d[i] = SCS_L_PU_H;
						dl_d[i] = '0;
					end
				end
				SCS_L_PU_C:
				begin
					co_d[i] = 1'b1;
					coe_d[i] = 1'b0;
					if (dl_q[i] == 4'(`SCS_PU_CYC - 1))
						ln_d[i] = SCS_L_IDLE;
				end
				SCS_L_PU_H:
				begin
					ho_d[i] = 1'b1;
					hoe_d[i] = 1'b0;
					if (dl_q[i] == 4'(`SCS_PU_CYC - 1))
						ln_d[i] = SCS_L_IDLE;
				end
				default:
					ln_d[i] = SCS_L_IDLE;
			endcase
			// Lines off: card contact held low, host side left to its pull-up
			if (!io_on)
			begin
				ln_d[i] = SCS_L_IDLE;
				co_d[i] = 1'b0;
				coe_d[i] = 1'b0;
				ho_d[i] = 1'b0;
				hoe_d[i] = 1'b1;
			end
		end
	end

	// Register lines and every top-level output
	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			for (int i = 0; i < 3; i++)
			begin
				ln_q[i] <= SCS_L_IDLE;
				dl_q[i] <= '0;
			end
			o_card_line_out <= '0;
			o_card_line_oe_n <= '0;
			o_host_line_out <= '0;
			o_host_line_oe_n <= 3'h7;
			o_card_clk <= 1'b0;
			o_card_rst <= 1'b0;
			o_vcc_en <= 1'b0;
			o_vcc_sel <= SCS_V3;
			o_gen_en <= 1'b0;
			o_osc_high <= 1'b0;
			o_hold <= 1'b1;
			o_alert_n <= `SCS_ALERT_RST;
		end
		else
		begin
			ln_q <= ln_d;
			dl_q <= dl_d;
			o_card_line_out <= co_d;
			o_card_line_oe_n <= coe_d;
			o_host_line_out <= ho_d;
			o_host_line_oe_n <= hoe_d;
			o_card_clk <= clk_d;
			// Reset drops as soon as the session ends, ahead of the queued word
			o_card_rst <= app_d[`SCS_W_RST] & s2_q.rst_req & in_sess;
			o_vcc_en <= app_d[`SCS_W_VCC];
			o_vcc_sel <= s2_q.lv ? SCS_V18 : (s2_q.hm ? SCS_V5 : SCS_V3);
			// Generator and fast oscillator run from t0 to the end of deactivation
			o_gen_en <= (st_d != SCS_HOLD) && (st_d != SCS_IDLE);
			o_osc_high <= (st_d != SCS_HOLD) && (st_d != SCS_IDLE);
			o_hold <= (st_d == SCS_HOLD);
			o_alert_n <= alert_d;
		end
	end
endmodule : scs_seq

// *** verif/scs_seq_properties.sv ***
// Port-level concurrent checks on the session sequencer, bound to its top
module scs_seq_chk (
	input wire logic i_clk,
	input wire logic i_rst,
	input wire logic i_session_request_n,
	input wire logic i_card_present_in,
	input wire logic i_fault_overload,
	input wire logic [2:0] i_host_line_in,
	input wire logic o_card_clk,
	input wire logic o_card_rst,
	input wire logic o_vcc_en,
	input wire logic o_gen_en,
	input wire logic o_osc_high,
	input wire logic o_hold,
	input wire logic o_alert_n,
	input wire logic [2:0] o_card_line_out,
	input wire logic [2:0] o_card_line_oe_n,
	input wire logic [2:0] o_host_line_oe_n
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (i_rst);
	// ************
	// Sequences
	// ************
	// All card contacts tied low
	sequence s_contacts_low;
		!o_card_clk && !o_card_rst && o_card_line_oe_n == 3'b000 && o_card_line_out == 3'b000;
	endsequence
	// Card reset dropped soon after a trigger
	sequence s_rst_drop;
		##[1:8] !o_card_rst;
	endsequence
	// ************
	// Assertions
	// ************
	a_hold_quiet: assert property (o_hold |-> !o_osc_high && !o_vcc_en)
		else $error("Session outputs active during hold");
	a_start_osc: assert property ($fell(i_session_request_n) && !o_hold && !o_gen_en && o_alert_n
		|-> ##[2:8] (o_osc_high && o_gen_en)) else $error("Activation did not start");
	a_idle_contacts: assert property (!o_gen_en
		|-> s_contacts_low ##0 (o_host_line_oe_n == 3'b111)) else $error("Idle contacts not low");
	a_vcc_order: assert property ($fell(o_vcc_en) |-> s_contacts_low)
		else $error("Supply dropped before contacts low");
	a_clk_needs_vcc: assert property (o_card_clk |-> o_vcc_en)
		else $error("Card clock without supply");
	a_rst_needs_vcc: assert property (o_card_rst |-> o_vcc_en)
		else $error("Card reset without supply");
	a_deact_rst: assert property (o_card_rst && $rose(i_session_request_n) |-> s_rst_drop)
		else $error("Card reset not dropped on session end");
	a_fault_rst: assert property (o_card_rst && $rose(i_fault_overload) |-> s_rst_drop)
		else $error("Card reset not dropped on fault");
	a_fault_alert: assert property (o_vcc_en && $rose(i_fault_overload)
		|-> ##[1:6] !o_alert_n) else $error("Fault not reported");
	a_removal_alert: assert property ($fell(i_card_present_in) |-> ##[1:5] !o_alert_n)
		else $error("Removal not reported");
	a_slave_edge: assert property ($fell(i_host_line_in[0]) && (&o_card_line_oe_n) && o_vcc_en
		|-> ##[5:12] (!o_card_line_oe_n[0] && !o_card_line_out[0])) else $error("Slave not low");
endmodule : scs_seq_chk

bind scs_seq scs_seq_chk u_chk (.i_clk, .i_rst, .i_session_request_n, .i_card_present_in,
	.i_fault_overload, .i_host_line_in, .o_card_clk, .o_card_rst, .o_vcc_en, .o_gen_en,
	.o_osc_high, .o_hold, .o_alert_n, .o_card_line_out, .o_card_line_oe_n, .o_host_line_oe_n);

// *** verif/scs_far_model.sv ***
// Far side model: crystal source, card data lines and card supply sensor
module scs_far_model #(
	parameter int XH = 10
) (
	input wire logic i_clk,
	input wire logic i_vcc_en,
	input wire logic [2:0] i_pull,
	input wire logic [2:0] i_line_out,
	input wire logic [2:0] i_line_oe_n,
	output logic o_xtal,
	output logic o_vcc_inactive,
	output logic [2:0] o_line
);
	timeunit 1ns;
	timeprecision 1ps;
	int xc = 0; // Crystal phase counter
	int vc = 0; // Cycles since supply switched off
	initial o_xtal = 1'b0;
	// Free-running crystal; supply decays 100 cycles after switch-off
	always @(posedge i_clk)
	begin
		xc <= (xc == XH - 1) ? 0 : xc + 1;
		if (xc == XH - 1)
			o_xtal <= !o_xtal;
		vc <= i_vcc_en ? 0 : ((vc < 100) ? vc + 1 : vc);
	end
	assign o_vcc_inactive = (vc >= 100);
	// Resistive pull-up: low only while the card or the device pulls down
	assign o_line = ~(i_pull | (~i_line_oe_n & ~i_line_out));
endmodule : scs_far_model

// *** verif/tb_top.sv ***
// Self-checking bench for the smart card session sequencer
`include "scs_defines.svh"
module tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	import scs_pkg::*;
	localparam int TK = `SCS_OSC_CYC; // Cycles per oscillator tick
	logic i_clk = 0, i_rst = 1, i_session_request_n = 1, i_card_present_in = 1;
	logic i_host_card_reset_req = 0, i_divide_select_a = 0, i_divide_select_b = 0;
	logic i_low_voltage_select = 0, i_high_mid_voltage_select = 0, i_supply_ok = 0;
	logic i_fault_overload = 0, i_fault_gen_range = 0, i_fault_overheat = 0;
	logic i_crystal_clock_in, i_vcc_inactive;
	logic [2:0] i_host_line_in, i_card_line_in, hpull = 0, cpull = 0;
	logic o_card_clk, o_card_rst, o_vcc_en, o_gen_en, o_osc_high, o_hold, o_alert_n;
	logic [2:0] o_card_line_out, o_card_line_oe_n, o_host_line_out, o_host_line_oe_n;
	scs_vsel_e o_vcc_sel;
	int err_total = 0, n_tests = 0, cyc = 0, t0 = 0, ts = 0, n = 0, edges = 0, e0 = 0;
	logic [1:0] sel_t [4] = '{2'b00, 2'b01, 2'b11, 2'b10}; // One bit changes per step
	int dv [4] = '{8, 4, 2, 1}; // Crystal edges per card clock half period
	// ************
	// Clock, timeout and wires
	// ************
	always #5 i_clk = ~i_clk;
	always @(posedge i_clk)
	begin
		cyc++;
		if (cyc == 90000)
		begin
			err_total++;
			conclude();
		end
	end
	always @(o_card_clk) edges++;
	// Host side has a pull-up too
	assign i_host_line_in = ~(hpull | (~o_host_line_oe_n & ~o_host_line_out));
	scs_seq #(.HOLD_CYC(20), .DEB_CYC(30)) DUT (.i_clk, .i_rst, .i_session_request_n,
		.i_card_present_in, .i_host_card_reset_req, .i_divide_select_a, .i_divide_select_b,
		.i_crystal_clock_in, .i_low_voltage_select, .i_high_mid_voltage_select, .i_supply_ok,
		.i_vcc_inactive, .i_fault_overload, .i_fault_gen_range, .i_fault_overheat,
		.i_host_line_in, .i_card_line_in, .o_card_clk, .o_card_rst, .o_vcc_en, .o_vcc_sel,
		.o_gen_en, .o_osc_high, .o_hold, .o_alert_n, .o_card_line_out, .o_card_line_oe_n,
		.o_host_line_out, .o_host_line_oe_n);
	scs_far_model #(.XH(10)) u_far (.i_clk(i_clk), .i_vcc_en(o_vcc_en), .i_pull(cpull),
		.i_line_out(o_card_line_out), .i_line_oe_n(o_card_line_oe_n),
		.o_xtal(i_crystal_clock_in), .o_vcc_inactive(i_vcc_inactive), .o_line(i_card_line_in));
	// ************
	// Access tasks
	// ************
	function automatic logic sig(input int k);
		case (k)
			0: return o_osc_high;
			1: return o_vcc_en;
			2: return o_card_clk;
			3: return o_card_rst;
			4: return o_alert_n;
			5: return &o_card_line_oe_n;
			6: return o_gen_en;
			7: return o_card_line_oe_n[0];
			8: return o_host_line_oe_n[1];
			9: return o_card_line_out[0];
			default: return o_hold;
		endcase
	endfunction : sig
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp)
		begin
			err_total++;
			$display("BAD %s exp %0h seen %0h", nm, exp, seen);
		end
	endtask : chk
	// Bounded wait for an output level, in falling-edge steps
	task automatic wt(input int k, input logic v, input int lim);
		n = 0;
		while (sig(k) !== v && n < lim)
		begin
			@(negedge i_clk);
			n++;
		end
		chk("wait_done", n < lim, 1'b1);
	endtask : wt
	task automatic cw(input int c);
		repeat (c) @(negedge i_clk);
	endtask : cw
	task automatic at(input string nm, input int lo, input int hi);
		chk(nm, (cyc - t0 >= lo) && (cyc - t0 <= hi), 1'b1);
	endtask : at
	task automatic till(input int tk);
		while (cyc - ts < tk * TK) @(negedge i_clk);
	endtask : till
	task automatic conclude();
		$display("checks %0d mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("NO MISMATCHES");
		else
			$display("MISMATCHES SEEN");
		$finish;
	endtask : conclude
	// ************
	// Scenarios
	// ************
	initial
	begin
		cw(16);
		i_rst = 0;
		chk("rst_out", {o_card_clk, o_card_rst, o_vcc_en, o_gen_en, o_hold, o_alert_n}, 6'h02);
		chk("rst_lines", {o_card_line_out, o_card_line_oe_n, o_host_line_oe_n}, 9'h007);
		// Request during hold must be refused
		i_session_request_n = 0;
		cw(10);
		i_supply_ok = 1;
		t0 = cyc;
		wt(10, 0, 60);
		at("hold_len", 18, 30);
		cw(10);
		chk("osc_in_hold", o_osc_high, 1'b0);
		i_session_request_n = 1;
		cw(4);
		wt(4, 1, 80);
		// Session one: automatic clock start one oscillator period after t3
		i_session_request_n = 0;
		t0 = cyc;
		ts = cyc;
		wt(0, 1, 10);
		chk("osc_gen", o_gen_en, 1'b1);
		wt(1, 1, 4000);
		at("vcc_on", 96 * TK, 96 * TK + 15);
		chk("vsel_3v", o_vcc_sel, SCS_V3);
		wt(5, 1, 7000);
		at("lines_on", 256 * TK, 256 * TK + 15);
		wt(2, 1, 400);
		at("clk_on", 257 * TK, 257 * TK + 120);
		till(450);
		chk("rst_low", o_card_rst, 1'b0);
		i_host_card_reset_req = 1;
		wt(3, 1, 10);
		i_host_card_reset_req = 0;
		wt(3, 0, 10);
		// Data line transfers, host side and card side as master
		hpull = 3'b001;
		t0 = cyc;
		wt(7, 0, 20);
		at("slave_low", 6, 11);
		hpull = 3'b000;
		wt(9, 1, 20);
		t0 = cyc;
		wt(7, 1, 20);
		at("pullup_len", 8, 12);
		cpull = 3'b010;
		t0 = cyc;
		wt(8, 0, 20);
		at("host_slave", 6, 11);
		cpull = 3'b000;
		wt(8, 1, 40);
		// Divide ratios, one select changed at a time
		for (int i = 0; i < 4; i++)
		begin
			{i_divide_select_a, i_divide_select_b} = sel_t[i];
			cw(300);
			wt(2, !o_card_clk, 200);
			t0 = cyc;
			wt(2, !o_card_clk, 200);
			at("half_period", dv[i] * 10 - 1, dv[i] * 10 + 1);
		end
		i_host_card_reset_req = 1;
		wt(3, 1, 10);
		// Host ends the session
		i_session_request_n = 1;
		t0 = cyc;
		wt(3, 0, 10);
		at("rst_off", 1, 8);
		wt(7, 0, 3000);
		at("lines_low", 64 * TK, 64 * TK + 15);
		chk("clk_low", o_card_clk, 1'b0);
		wt(1, 0, 2000);
		at("vcc_off", 96 * TK, 96 * TK + 15);
		wt(6, 0, 300);
		chk("osc_slow", {o_osc_high, o_alert_n}, 2'b01);
		// Session two: host-timed clock, low voltage, then overload
		i_low_voltage_select = 1;
		i_host_card_reset_req = 1;
		cw(20);
		i_session_request_n = 0;
		ts = cyc;
		e0 = edges;
		chk("no_clk", o_card_clk, 1'b0);
		wt(1, 1, 4000);
		chk("vsel_18", o_vcc_sel, SCS_V18);
		till(300);
		chk("clk_held", edges - e0, 0);
		i_host_card_reset_req = 0;
		t0 = cyc;
		wt(2, 1, 100);
		at("clk_by_req", 2, 40);
		till(450);
		i_host_card_reset_req = 1;
		wt(3, 1, 10);
		i_fault_overload = 1;
		t0 = cyc;
		wt(4, 0, 10);
		at("fault_alert", 1, 6);
		wt(1, 0, 4000);
		at("fault_vcc_off", 96 * TK, 96 * TK + 20);
		i_fault_overload = 0;
		i_host_card_reset_req = 0;
		i_session_request_n = 1;
		wt(6, 0, 300);
		wt(4, 1, 20);
		// Session three: five volts, card pulled out
		i_low_voltage_select = 0;
		cw(20);
		i_high_mid_voltage_select = 1;
		i_session_request_n = 0;
		wt(1, 1, 4000);
		chk("vsel_5v", o_vcc_sel, SCS_V5);
		i_card_present_in = 0;
		t0 = cyc;
		wt(4, 0, 10);
		at("removal", 1, 5);
		wt(1, 0, 4000);
		i_session_request_n = 1;
		wt(6, 0, 300);
		cw(20);
		chk("removed", o_alert_n, 1'b0);
		i_card_present_in = 1;
		t0 = cyc;
		wt(4, 1, 60);
		at("debounce", 30, 36);
		conclude();
	end
endmodule : tb_top
